// ==== inc/adctr_consts.vh ====
/*
 * constants of the converter control block: register byte addresses,
 * field positions and reset values.
 * assumes: included by the design file by its bare name.
 */
`ifndef ADCTR_CONSTS_VH
`define ADCTR_CONSTS_VH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define ADCTR_CTRL_ADDR     32'h4001C000
`define ADCTR_GRES_ADDR     32'h4001C004
`define ADCTR_IEN_ADDR      32'h4001C00C
`define ADCTR_CH0_ADDR      32'h4001C010
`define ADCTR_CH7_ADDR      32'h4001C02C

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define ADCTR_SEL_HI        7
`define ADCTR_SEL_LO        0
`define ADCTR_BURST_BIT     16
`define ADCTR_START_HI      26
`define ADCTR_START_LO      24
`define ADCTR_EDGE_BIT      27
`define ADCTR_CTRL_KEEP     32'h0FFFFFFF
`define ADCTR_CTRL_RST      32'h00000000

// start field codes
`define ADCTR_START_NONE    3'h0
`define ADCTR_START_NOW     3'h1
`define ADCTR_START_EXT     3'h2

// ----------------------------------------------------------------------
// result and interrupt-enable fields
// ----------------------------------------------------------------------
`define ADCTR_VAL_LO        6
`define ADCTR_CHN_LO        24
`define ADCTR_OVR_BIT       30
`define ADCTR_DONE_BIT      31
`define ADCTR_GIEN_BIT      8
`define ADCTR_IEN_RST       9'h100

`endif

// ==== hdl/adctr_top.v ====
/*
 * converter control: start-trigger selection with edge choice, global
 * and per-channel result registers with clear-on-read flags (the global
 * overrun flag is rewritten only by the next result), interrupt enable
 * mask and the combined interrupt request, behind an AHB-Lite
 * slave with zero wait states.
 * assumes: the analog converter runs on clk, takes a one-cycle start
 * pulse and answers with a one-cycle done pulse carrying value and
 * channel; timer match lines are on clk; capture pins are asynchronous.
 */
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "adctr_consts.vh"

module adctr_top (
    input  wire        clk,                 // system clock, 250 MHz
    input  wire        rst,                 // synchronous reset, high
    // ahb-lite slave
    input  wire        hsel,                // slave select
    input  wire [31:0] haddr,               // byte address
    input  wire [1:0]  htrans,              // transfer type
    input  wire        hwrite,              // write when high
    input  wire [2:0]  hsize,               // word only
    input  wire [31:0] hwdata,              // write data
    input  wire        hready,              // bus ready
    output reg  [31:0] hrdata_ff,           // read data
    output reg         hreadyout_ff,        // ready except during reset
    output reg         hresp_ff,            // always okay
    // trigger sources
    input  wire        capture_trigger_pin_a, // async pin
    input  wire        capture_trigger_pin_b, // async pin
    input  wire        wide_timer_match0,   // on clk
    input  wire        wide_timer_match1,   // on clk
    input  wire        narrow_timer_match0, // on clk
    input  wire        narrow_timer_match1, // on clk
    // analog converter side
    output reg         conv_start_ff,       // one-cycle start pulse
    output reg  [7:0]  conv_sel_ff,         // channel select field
    output reg         conv_burst_ff,       // burst mode bit
    input  wire        conv_done,           // one-cycle done pulse
    input  wire [9:0]  conv_value,          // result with conv_done
    input  wire [2:0]  conv_channel,        // channel with conv_done
    // interrupt request
    output reg         converter_irq_flag_ff // level request
);

    // channel count; the result index field is three bits wide
    parameter NCH = 8;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // result word layout shared by global and channel registers
    // reserved bits are cleared first so they can never leak stale data
    function [31:0] pack_result;
        input [9:0] val;
        input [2:0] result_channel;
        input       ovr;
        input       done;
        begin
            pack_result = 32'h00000000;
            pack_result[`ADCTR_VAL_LO +: 10] = val;
            pack_result[`ADCTR_CHN_LO +: 3] = result_channel;
            pack_result[`ADCTR_OVR_BIT] = ovr;
            pack_result[`ADCTR_DONE_BIT] = done;
        end
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    // registers visible to software and the converter result store;
    // channel values sit in a small array, one ten-bit value per channel
    reg [31:0] conv_control_ff;
    reg [8:0]  irq_enable_mask_ff;
    reg [9:0]  g_val_ff;
    reg [2:0]  g_chn_ff;
    reg        g_ovr_ff;
    reg        g_done_ff;
    reg [9:0]  ch_val_ff [0:NCH-1];
    reg [NCH-1:0] ch_done_ff;
    reg [NCH-1:0] ch_ovr_ff;
    reg        busy_ff;
    reg        dp_valid_ff;
    reg        dp_write_ff;
    reg [31:0] dp_addr_ff;
    reg [2:0]  pin_a_sync_ff;
    reg [2:0]  pin_b_sync_ff;
    reg [1:0]  pin_lvl_ff;
    reg [5:0]  trig_prev_ff;

    reg        nxt_g_done;
    reg        nxt_start;
    reg [31:0] nxt_rdata;
    reg [NCH-1:0] ch_rd_clr;
    reg        trig_hit;

    wire       addr_take;
    wire       ctrl_wr;
    wire       ien_wr;
    wire       gres_rd;
    wire [5:0] trig_now;
    wire [2:0] start_code;
    wire [2:0] trig_idx;
    wire       burst;
    integer    i;
    integer    j;

    // ------------------------------------------------------------------
    // ahb address / data phase
    // ------------------------------------------------------------------
    // a transfer is taken only with hready high, so a stalled bus
    // never latches a phantom address phase; writes act in the data
    // phase, when hwdata is valid
    assign addr_take = hsel & htrans[1] & hready;
    assign ctrl_wr = dp_valid_ff & dp_write_ff &
                     (dp_addr_ff == `ADCTR_CTRL_ADDR);
    assign ien_wr  = dp_valid_ff & dp_write_ff &
                     (dp_addr_ff == `ADCTR_IEN_ADDR);
    assign gres_rd = addr_take & ~hwrite & (haddr == `ADCTR_GRES_ADDR);

    // data-phase bookkeeping; the slave never stretches a transfer
    // hreadyout stays low during reset so no master starts early;
    // hsize is ignored because every register is a whole word
    // the response is always okay; there is no error path
    always @(posedge clk) begin
        if (rst) begin
            dp_valid_ff  <= 1'b0;
            dp_write_ff  <= 1'b0;
            dp_addr_ff   <= 32'h00000000;
            hreadyout_ff <= 1'b0;
            hresp_ff     <= 1'b0;
        end else begin
            dp_valid_ff  <= addr_take;
            dp_write_ff  <= hwrite;
            dp_addr_ff   <= haddr;
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
        end
    end

    // read mux, evaluated in the address phase so hrdata is a flop;
    // the clear-on-read side effect fires on the same edge
    // unmapped reads return zero rather than a stale word
    always @* begin
        nxt_rdata = 32'h00000000;
        ch_rd_clr = {NCH{1'b0}};
        if (addr_take & ~hwrite) begin
            if (haddr == `ADCTR_CTRL_ADDR) begin
                // top nibble returned as zero, allowed as undefined
                nxt_rdata = conv_control_ff & `ADCTR_CTRL_KEEP;
            end else if (haddr == `ADCTR_GRES_ADDR) begin
                nxt_rdata = pack_result(g_val_ff, g_chn_ff,
                                        g_ovr_ff, g_done_ff);
            end else if (haddr == `ADCTR_IEN_ADDR) begin
                nxt_rdata = {23'h000000, irq_enable_mask_ff};
            end else begin
                for (i = 0; i < NCH; i = i + 1) begin
                    if (haddr == `ADCTR_CH0_ADDR + 4 * i) begin
                        nxt_rdata = pack_result(ch_val_ff[i],
                                        i[2:0], ch_ovr_ff[i],
                                        ch_done_ff[i]);
                        ch_rd_clr[i] = 1'b1;
                    end
                end
            end
        end
    end

    // read data drops back to zero after its data phase, so a
    // stale word is never mistaken for a fresh read
    always @(posedge clk) begin
        if (rst)
            hrdata_ff <= 32'h00000000;
        else
            hrdata_ff <= nxt_rdata;
    end

    // ------------------------------------------------------------------
    // control and interrupt enable registers
    // ------------------------------------------------------------------
    // the top nibble of control is not stored: software is expected
    // to write zeros there and a read shows zeros
    always @(posedge clk) begin
        if (rst) begin
            conv_control_ff    <= `ADCTR_CTRL_RST;
            irq_enable_mask_ff <= `ADCTR_IEN_RST;
        end else begin
            if (ctrl_wr)
                conv_control_ff <= hwdata & `ADCTR_CTRL_KEEP;
            if (ien_wr)
                irq_enable_mask_ff <= hwdata[8:0];
        end
    end

    // ------------------------------------------------------------------
    // trigger synchronisers and edge detection
    // ------------------------------------------------------------------
    // pin level is accepted only when stages two and three agree
    // the first stage may go metastable, so only later stages are
    // compared; a glitch shorter than two clocks is filtered out
    // a capture edge reaches the detector three to four clocks late
    always @(posedge clk) begin
        if (rst) begin
            pin_a_sync_ff <= 3'h0;
            pin_b_sync_ff <= 3'h0;
            pin_lvl_ff    <= 2'h0;
            trig_prev_ff  <= 6'h00;
        end else begin
            pin_a_sync_ff <= {pin_a_sync_ff[1:0], capture_trigger_pin_a};
            pin_b_sync_ff <= {pin_b_sync_ff[1:0], capture_trigger_pin_b};
            if (pin_a_sync_ff[1] == pin_a_sync_ff[2])
                pin_lvl_ff[0] <= pin_a_sync_ff[2];
            if (pin_b_sync_ff[1] == pin_b_sync_ff[2])
                pin_lvl_ff[1] <= pin_b_sync_ff[2];
            trig_prev_ff <= trig_now;
        end
    end

    // match lines come straight from the timers, no pin involved
    // order of bits follows the start codes 2 to 7
    assign trig_now = {narrow_timer_match1, narrow_timer_match0,
                       wide_timer_match1, wide_timer_match0,
                       pin_lvl_ff};
    assign start_code = conv_control_ff[`ADCTR_START_HI:`ADCTR_START_LO];
    assign burst = conv_control_ff[`ADCTR_BURST_BIT];
    assign trig_idx = start_code - `ADCTR_START_EXT;

    // one edge compares current against previous sample: one start only
    // previous samples track every cycle even while another code is
    // selected, so switching codes never fakes an edge
    always @* begin
        trig_hit = 1'b0;
        if (~burst && start_code >= `ADCTR_START_EXT) begin
            if (conv_control_ff[`ADCTR_EDGE_BIT])
                trig_hit = ~trig_now[trig_idx] & trig_prev_ff[trig_idx];
            else
                trig_hit = trig_now[trig_idx] & ~trig_prev_ff[trig_idx];
        end
    end

    // ------------------------------------------------------------------
    // start generation and busy tracking
    // ------------------------------------------------------------------
    // a control write while busy restarts; start code 1 starts at once
    // burst mode suppresses start-code-1 and trigger starts but not a busy restart; burst scanning
    // itself is sequenced outside this block
    // a restart on a busy write re-uses whatever channel is selected
    always @* begin
        nxt_start = trig_hit;
        if (ctrl_wr) begin
            if (busy_ff)
                nxt_start = 1'b1;
            else if (~hwdata[`ADCTR_BURST_BIT] &&
                     hwdata[`ADCTR_START_HI:`ADCTR_START_LO] ==
                     `ADCTR_START_NOW)
                nxt_start = 1'b1;
        end
    end

    // busy spans from the start pulse to the converter's done pulse
    always @(posedge clk) begin
        if (rst) begin
            conv_start_ff <= 1'b0;
            busy_ff       <= 1'b0;
            conv_sel_ff   <= 8'h00;
            conv_burst_ff <= 1'b0;
        end else begin
            conv_start_ff <= nxt_start;
            if (nxt_start)
                busy_ff <= 1'b1;
            else if (conv_done)
                busy_ff <= 1'b0;
            conv_sel_ff   <= conv_control_ff[`ADCTR_SEL_HI:`ADCTR_SEL_LO];
            conv_burst_ff <= burst;
        end
    end

    // ------------------------------------------------------------------
    // global result register
    // ------------------------------------------------------------------
    // a finishing conversion beats any clear arriving in the same cycle
    // so a result is never lost; a control write while idle clears done
    always @* begin
        if (conv_done)
            nxt_g_done = 1'b1;
        else if (ctrl_wr)
            nxt_g_done = busy_ff;
        else if (gres_rd)
            nxt_g_done = 1'b0;
        else
            nxt_g_done = g_done_ff;
    end

    // overrun is only rewritten by the next result, not by a read;
    // software that needs it must read before the next conversion
    always @(posedge clk) begin
        if (rst) begin
            g_val_ff  <= 10'h000;
            g_chn_ff  <= 3'h0;
            g_ovr_ff  <= 1'b0;
            g_done_ff <= 1'b0;
        end else begin
            g_done_ff <= nxt_g_done;
            if (conv_done) begin
                g_val_ff <= conv_value;
                g_chn_ff <= conv_channel;
                g_ovr_ff <= burst & g_done_ff;
            end
        end
    end

    // ------------------------------------------------------------------
    // per-channel result registers
    // ------------------------------------------------------------------
    // new result wins over a read clear of the same channel
    // a read of one channel leaves the flags of the others untouched
    // channel values reset to zero although software sees no flag
    always @(posedge clk) begin
        if (rst) begin
            ch_done_ff <= {NCH{1'b0}};
            ch_ovr_ff  <= {NCH{1'b0}};
            for (j = 0; j < NCH; j = j + 1)
                ch_val_ff[j] <= 10'h000;
        end else begin
            for (j = 0; j < NCH; j = j + 1) begin
                if (conv_done && conv_channel == j[2:0]) begin
                    ch_val_ff[j]  <= conv_value;
                    ch_done_ff[j] <= 1'b1;
                    ch_ovr_ff[j]  <= burst & ch_done_ff[j];
                end else if (ch_rd_clr[j]) begin
                    ch_done_ff[j] <= 1'b0;
                    ch_ovr_ff[j]  <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------------
    // level request, one cycle behind the flags; it drops once every
    // enabled flag has been cleared by its read
    always @(posedge clk) begin
        if (rst)
            converter_irq_flag_ff <= 1'b0;
        else
            converter_irq_flag_ff <=
                (|(ch_done_ff & irq_enable_mask_ff[7:0])) |
                (g_done_ff & irq_enable_mask_ff[`ADCTR_GIEN_BIT]);
    end

endmodule // adctr_top

// ==== tb/adctr_monitor.sv ====
/* checker for the converter control block: bus reads, start pulses
   and the interrupt request, seen only at the top ports.
   assumes: bound to adctr_top, one slave, hready = hreadyout_ff. */
`timescale 1ns/1ps
`include "adctr_consts.vh"

module adctr_monitor (
    input logic        clk,                   // clock
    input logic        rst,                   // sync reset
    input logic        hsel,                  // select
    input logic [31:0] haddr,                 // address
    input logic [1:0]  htrans,                // transfer
    input logic        hwrite,                // write
    input logic [31:0] hwdata,                // write data
    input logic        hready,                // ready
    input logic [31:0] hrdata_ff,             // read data
    input logic        wide_timer_match0,     // timer match
    input logic        conv_start_ff,         // start pulse
    input logic        conv_done,             // done pulse
    input logic [2:0]  conv_channel,          // done channel
    input logic        converter_irq_flag_ff  // request
);
    logic        ap;
    logic        wr_ff;
    logic        rd_ff;
    logic [31:0] a_ff;
    logic [31:0] ctl_ff;
    logic [8:0]  ien_ff;

    // shadows of control and enable, updated at the write data edge
    assign ap = hsel & htrans[1] & hready;
    always @(posedge clk) begin
        if (rst) begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            a_ff <= 32'h0;
            ctl_ff <= 32'h0;
            ien_ff <= 9'h100;
        end else begin
            wr_ff <= ap & hwrite;
            rd_ff <= ap & ~hwrite;
            a_ff <= haddr;
            if (wr_ff && a_ff == `ADCTR_CTRL_ADDR) ctl_ff <= hwdata;
            if (wr_ff && a_ff == `ADCTR_IEN_ADDR) ien_ff <= hwdata[8:0];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_wr(logic [31:0] ad);
        wr_ff && a_ff == ad;
    endsequence
    sequence s_rd(logic [31:0] ad);
        rd_ff && a_ff == ad;
    endsequence

    AST_NOW: assert property (s_wr(`ADCTR_CTRL_ADDR) ##0
        (hwdata[26:24] == 3'h1 && !hwdata[16]) |=> conv_start_ff)
        else $error("no start after immediate start write");
    AST_RISE: assert property (ctl_ff[27:24] == 4'h4 && !ctl_ff[16]
        && $rose(wide_timer_match0) |=> ##[0:1] conv_start_ff)
        else $error("no start on rising match");
    AST_FALL: assert property (ctl_ff[27:24] == 4'hC && !ctl_ff[16]
        && $fell(wide_timer_match0) |=> ##[0:1] conv_start_ff)
        else $error("no start on falling match");
    AST_GZERO: assert property (s_rd(`ADCTR_GRES_ADDR) |->
        (hrdata_ff & 32'h38FF003F) == 32'h0)
        else $error("unused result bits not zero");
    AST_IEN: assert property (s_rd(`ADCTR_IEN_ADDR) |->
        hrdata_ff == {23'h0, ien_ff})
        else $error("enable readback wrong");
    AST_CHIRQ: assert property (conv_done && ien_ff[conv_channel]
        |-> ##2 converter_irq_flag_ff)
        else $error("channel interrupt missing");
    AST_GLIRQ: assert property (conv_done && ien_ff[8]
        |-> ##2 converter_irq_flag_ff)
        else $error("global interrupt missing");
    AST_NOIRQ: assert property (ien_ff == 9'h0 && $past(ien_ff) == 9'h0
        |-> !converter_irq_flag_ff)
        else $error("interrupt with nothing enabled");
endmodule // adctr_monitor

bind adctr_top adctr_monitor u_mon (.clk, .rst, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata_ff, .wide_timer_match0,
    .conv_start_ff, .conv_done, .conv_channel, .converter_irq_flag_ff);

// ==== tb/adc_trigger_result_irq_bench.sv ====
/* self-checking bench for the converter control block.
   assumes: single AHB-Lite slave, converter played by the bench. */
`timescale 1ns/1ps
`include "adctr_consts.vh"

module adc_trigger_result_irq_bench;
    localparam logic [31:0] CTL = `ADCTR_CTRL_ADDR;
    localparam logic [31:0] GRS = `ADCTR_GRES_ADDR;
    localparam logic [31:0] IEN = `ADCTR_IEN_ADDR;
    localparam logic [31:0] CH0 = `ADCTR_CH0_ADDR;
    logic        clk, rst, hsel, hwrite, conv_done;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0]  htrans;
    logic [9:0]  conv_value;
    logic [2:0]  conv_channel;
    logic [5:0]  trig;
    wire  [31:0] hrdata_ff;
    wire  [7:0]  conv_sel_ff;
    wire         hready, hresp_ff, conv_start_ff, conv_burst_ff, irq;
    int          n_errors = 0, checked = 0, n_starts = 0, s;

    adctr_top dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hrdata_ff,
        .hreadyout_ff(hready), .hresp_ff,
        .capture_trigger_pin_a(trig[0]), .capture_trigger_pin_b(trig[1]),
        .wide_timer_match0(trig[2]), .wide_timer_match1(trig[3]),
        .narrow_timer_match0(trig[4]), .narrow_timer_match1(trig[5]),
        .conv_start_ff, .conv_sel_ff, .conv_burst_ff, .conv_done,
        .conv_value, .conv_channel, .converter_irq_flag_ff(irq));

    // ------------------------------------------------------------------
    // clock, start counter and shared tasks
    // ------------------------------------------------------------------
    always #2 clk = ~clk;
    always @(posedge clk) if (conv_start_ff === 1'b1) n_starts <= n_starts + 1;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one single transfer; holds each phase until hready is seen high
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
             output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata_ff;
    endtask
    // the converter finishes one conversion
    task finish(input logic [9:0] v, input logic [2:0] ch);
        @(posedge clk);
        conv_done <= 1'b1;
        conv_value <= v;
        conv_channel <= ch;
        @(posedge clk);
        conv_done <= 1'b0;
    endtask
    task give_verdict;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task t_reset;
        chk({31'h0, irq}, 32'h0);
        ahb(1'b0, IEN, 32'h0, rd);
        chk(rd, 32'h00000100);
        ahb(1'b0, GRS, 32'h0, rd);
        chk(rd & 32'hC0000000, 32'h0);
    endtask
    task t_now;
        s = n_starts;
        ahb(1'b1, CTL, 32'h01000000, rd);
        repeat (4) @(posedge clk);
        chk(32'(n_starts - s), 32'h1);
        finish(10'h3FF, 3'h5);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        ahb(1'b0, GRS, 32'h0, rd);
        chk(rd, 32'h8500FFC0);
        ahb(1'b0, GRS, 32'h0, rd);
        chk(rd, 32'h0500FFC0);
        ahb(1'b0, CH0 + 32'h14, 32'h0, rd);
        chk(rd & 32'hF8FFFFFF, 32'h8000FFC0);
        ahb(1'b0, CH0 + 32'h14, 32'h0, rd);
        chk(rd & 32'hF8FFFFFF, 32'h0000FFC0);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
    endtask
    // control writes while busy and while idle
    task t_busy;
        ahb(1'b1, CTL, 32'h01000000, rd);
        repeat (2) @(posedge clk);
        s = n_starts;
        ahb(1'b1, CTL, 32'h0, rd);
        repeat (4) @(posedge clk);
        chk(32'(n_starts - s), 32'h1);
        ahb(1'b0, GRS, 32'h0, rd);
        chk(rd & 32'h80000000, 32'h80000000);
        finish(10'h001, 3'h2);
        ahb(1'b1, CTL, 32'h0, rd);
        ahb(1'b0, GRS, 32'h0, rd);
        chk(rd & 32'h80000000, 32'h0);
    endtask
    // every edge-triggered start code, both edges, others toggled too
    task t_trig;
        for (int c = 2; c < 8; c++)
            for (int e = 0; e < 2; e++) begin
                s = n_starts;
                ahb(1'b1, CTL, 32'h0, rd);
                trig <= {6{e[0]}};
                repeat (8) @(posedge clk);
                ahb(1'b1, CTL, {4'h0, e[0], c[2:0], 24'h0}, rd);
                trig <= ~{6{e[0]}} ^ (6'h1 << (c - 2));
                repeat (10) @(posedge clk);
                chk(32'(n_starts - s), 32'h0);
                trig[c - 2] <= ~e[0];
                repeat (10) @(posedge clk);
                chk(32'(n_starts - s), 32'h1);
                finish(10'h0, 3'h0);
                trig[c - 2] <= e[0];
                repeat (10) @(posedge clk);
                chk(32'(n_starts - s), 32'h1);
            end
    endtask
    task t_irq;
        ahb(1'b1, IEN, 32'hFFFFFFFF, rd);
        ahb(1'b0, IEN, 32'h0, rd);
        chk(rd, 32'h000001FF);
        ahb(1'b1, IEN, 32'h00000004, rd);
        ahb(1'b0, CH0 + 32'h8, 32'h0, rd);
        finish(10'h0, 3'h3);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        finish(10'h0, 3'h2);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        ahb(1'b0, CH0 + 32'h8, 32'h0, rd);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        ahb(1'b1, GRS + 32'h4, 32'hFFFFFFFF, rd);
        ahb(1'b0, GRS + 32'h4, 32'h0, rd);
        chk(rd, 32'h0);
    endtask
    // two results with no read between them in burst mode
    task t_burst;
        ahb(1'b1, IEN, 32'h0, rd);
        ahb(1'b1, CTL, 32'h000100A5, rd);
        ahb(1'b0, GRS, 32'h0, rd);
        finish(10'h155, 3'h1);
        finish(10'h2AA, 3'h4);
        ahb(1'b0, GRS, 32'h0, rd);
        chk(rd, 32'hC400AA80);
        chk({31'h0, conv_burst_ff}, 32'h1);
        chk({24'h0, conv_sel_ff}, 32'h000000A5);
        chk({31'h0, hresp_ff}, 32'h0);
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        conv_done = 1'b0;
        conv_value = 10'h0;
        conv_channel = 3'h0;
        trig = 6'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_now;
        t_busy;
        t_trig;
        t_irq;
        t_burst;
        give_verdict;
    end
    // cut a hang short well past the expected run of several hundred cycles
    initial begin
        #80000;
        n_errors++;
        give_verdict;
    end
endmodule // adc_trigger_result_irq_bench
